// [design/owvc_dev.sv]
// Device end: pulse-width bit decoder, acknowledge driver and mode control.
// Assumes the wire level arrives synchronous to ref_clk_i.
`timescale 1ns/1ps

module owvc_dev #(
  parameter logic [16:0] FIRST_MAX_CYC = owvc_pkg::FIRST_MAX_CYC,
  parameter logic [16:0] SECOND_MAX_CYC = owvc_pkg::SECOND_MAX_CYC,
  parameter logic [16:0] TIMEOUT_CYC = owvc_pkg::TIMEOUT_CYC,
  parameter logic [16:0] ACK_CYC = owvc_pkg::ACK_MIN_CYC
) (
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  owvc_if.dev link,
  input wire logic ack_en_i,
  output logic [7:0] data_o,
  output logic data_valid_o,
  output logic frame_err_o,
  output logic save_mode_o,
  output logic pwm_force_o
);

  typedef struct packed {
    owvc_pkg::owvc_dstate_t st;
    logic line;
    logic [16:0] cnt;
    logic [16:0] lo_len;
    logic [16:0] acnt;
    logic [2:0] nbits;
    logic [7:0] shreg;
    logic [7:0] data;
    logic data_valid;
    logic frame_err;
    logic save_mode;
    logic pwm_force;
    logic oe;
  } owvc_dev_st_t;

  owvc_dev_st_t r_reg;
  owvc_dev_st_t r_next;
  logic line_now;
  logic edge_seen;
  logic rise;
  logic fall;
  logic ack_busy;
  logic timeout_hit;
  logic static_hit;
  logic one_ok;
  logic zero_ok;
  logic in_frame;

  assign line_now = link.line;
  assign edge_seen = line_now != r_reg.line;
  assign rise = line_now && !r_reg.line;
  assign fall = !line_now && r_reg.line;
  assign ack_busy = (r_reg.st == owvc_pkg::OWVC_D_ACK) || (r_reg.st == owvc_pkg::OWVC_D_REL);
  // Own acknowledge pulse must not count as host low time
  assign timeout_hit = !ack_busy && !line_now && !r_reg.line
                       && (r_reg.cnt >= TIMEOUT_CYC);
  assign static_hit = !ack_busy && line_now && r_reg.line
                      && (r_reg.cnt > SECOND_MAX_CYC);
  assign in_frame = (r_reg.st == owvc_pkg::OWVC_D_LOW) || (r_reg.st == owvc_pkg::OWVC_D_HIGH)
                    || (r_reg.st == owvc_pkg::OWVC_D_EOS);

  // Bit checks at the falling edge that ends the high phase; r_reg.cnt is its length
  assign one_ok = (r_reg.lo_len >= owvc_pkg::PHASE_MIN_CYC)
                  && (r_reg.lo_len <= FIRST_MAX_CYC)
                  && ({1'b0, r_reg.cnt} >= {r_reg.lo_len, 1'b0})
                  && (r_reg.cnt <= SECOND_MAX_CYC);
  assign zero_ok = (r_reg.cnt >= owvc_pkg::PHASE_MIN_CYC)
                   && (r_reg.cnt <= FIRST_MAX_CYC)
                   && ({1'b0, r_reg.lo_len} >= {r_reg.cnt, 1'b0})
                   && (r_reg.lo_len <= SECOND_MAX_CYC);

  always_comb
  begin
    r_next = r_reg;
    r_next.data_valid = 1'b0;
    r_next.frame_err = 1'b0;
    r_next.line = line_now;
    if (edge_seen)
    begin
      r_next.cnt = 17'h0_0001;
    end
    else if (r_reg.cnt != 17'h1_ffff)
    begin
      r_next.cnt = r_reg.cnt + 17'h0_0001;
    end

    if (timeout_hit)
    begin
      r_next.save_mode = 1'b1;
      r_next.pwm_force = 1'b0;
    end
    else if (static_hit)
    begin
      r_next.pwm_force = 1'b1;
      r_next.save_mode = 1'b0;
    end

    if (in_frame && (timeout_hit || static_hit))
    begin
      // Partial frame is dropped rather than half applied
      r_next.st = owvc_pkg::OWVC_D_IDLE;
      r_next.frame_err = 1'b1;
    end
    else
    begin
      case (r_reg.st)
        owvc_pkg::OWVC_D_IDLE:
        begin
          // Frame opens on a fall after a long enough high
          if (fall && (r_reg.cnt >= owvc_pkg::START_MIN_CYC))
          begin
            r_next.st = owvc_pkg::OWVC_D_LOW;
            r_next.nbits = 3'h0;
          end
        end
        owvc_pkg::OWVC_D_LOW:
        begin
          if (rise)
          begin
            r_next.lo_len = r_reg.cnt;
            r_next.st = owvc_pkg::OWVC_D_HIGH;
          end
        end
        owvc_pkg::OWVC_D_HIGH:
        begin
          if (fall)
          begin
            if (one_ok || zero_ok)
            begin
              r_next.shreg = {r_reg.shreg[6:0], one_ok};
              r_next.nbits = r_reg.nbits + 3'h1;
              if (r_reg.nbits == owvc_pkg::LAST_BIT)
              begin
                r_next.data = {r_reg.shreg[6:0], one_ok};
                r_next.data_valid = 1'b1;
                r_next.st = owvc_pkg::OWVC_D_EOS;
              end
              else
              begin
                r_next.st = owvc_pkg::OWVC_D_LOW;
              end
            end
            else
            begin
              r_next.frame_err = 1'b1;
              r_next.st = owvc_pkg::OWVC_D_IDLE;
            end
          end
        end
        owvc_pkg::OWVC_D_EOS:
        begin
          // End of stream: host low phase, then release
          if (rise)
          begin
            if (r_reg.cnt < owvc_pkg::EOS_MIN_CYC)
            begin
              r_next.frame_err = 1'b1;
              r_next.st = owvc_pkg::OWVC_D_IDLE;
            end
            else if (ack_en_i)
            begin
              r_next.st = owvc_pkg::OWVC_D_ACK;
              r_next.oe = 1'b1;
              r_next.acnt = 17'h0_0000;
            end
            else
            begin
              r_next.st = owvc_pkg::OWVC_D_IDLE;
            end
          end
        end
        owvc_pkg::OWVC_D_ACK:
        begin
          r_next.acnt = r_reg.acnt + 17'h0_0001;
          if (r_reg.acnt == (ACK_CYC - 17'h0_0001))
          begin
            r_next.oe = 1'b0;
            r_next.st = owvc_pkg::OWVC_D_REL;
          end
        end
        owvc_pkg::OWVC_D_REL:
        begin
          // Wait for the pull-up before looking for a new frame
          if (line_now)
          begin
            r_next.st = owvc_pkg::OWVC_D_IDLE;
          end
        end
        default:
        begin
          r_next.st = owvc_pkg::OWVC_D_IDLE;
          r_next.oe = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      r_reg.st <= owvc_pkg::OWVC_D_IDLE;
      r_reg.line <= 1'b1;
      r_reg.cnt <= 17'h0_0000;
      r_reg.lo_len <= 17'h0_0000;
      r_reg.acnt <= 17'h0_0000;
      r_reg.nbits <= 3'h0;
      r_reg.shreg <= 8'h00;
      r_reg.data <= 8'h00;
      r_reg.data_valid <= 1'b0;
      r_reg.frame_err <= 1'b0;
      r_reg.save_mode <= owvc_pkg::SAVE_MODE_RST;
      r_reg.pwm_force <= owvc_pkg::PWM_FORCE_RST;
      r_reg.oe <= 1'b0;
    end
    else
    begin
      r_reg <= r_next;
    end
  end

  // Only ever pulls low; the high level is the pull-up's
  assign link.dev_o = 1'b0;
  assign link.dev_oe = r_reg.oe;
  assign data_o = r_reg.data;
  assign data_valid_o = r_reg.data_valid;
  assign frame_err_o = r_reg.frame_err;
  assign save_mode_o = r_reg.save_mode;
  assign pwm_force_o = r_reg.pwm_force;

endmodule

// [design/owvc_host.sv]
// Host end: sends one byte per request as pulse-width coded bits.
// Assumes the device acknowledges by pulling the released wire low.
`timescale 1ns/1ps
module owvc_host #(
  parameter logic [16:0] ACK_MIN_CYC = owvc_pkg::ACK_MIN_CYC,
  parameter logic [16:0] ACK_MAX_CYC = owvc_pkg::ACK_MAX_CYC
) (
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  owvc_if.host link,
  input wire logic send_i,
  input wire logic [7:0] data_i,
  input wire logic idle_high_i,
  output logic busy_o,
  output logic done_o,
  output logic ack_o
);

  typedef struct packed {
    owvc_pkg::owvc_hstate_t st;
    logic [16:0] cnt;
    logic [2:0] idx;
    logic [7:0] sh;
    logic lvl;
    logic oe;
    logic busy;
    logic done;
    logic ack;
  } owvc_host_st_t;

  owvc_host_st_t r_reg;
  owvc_host_st_t r_next;
  logic [16:0] low_len;
  logic [16:0] high_len;
  logic [16:0] cnt_inc;

  // A one is a short low then a long high, a zero the reverse; ratio 3 to 1
  assign low_len = r_reg.sh[7] ? owvc_pkg::H_SHORT_CYC : owvc_pkg::H_LONG_CYC;
  assign high_len = r_reg.sh[7] ? owvc_pkg::H_LONG_CYC : owvc_pkg::H_SHORT_CYC;
  assign cnt_inc = r_reg.cnt + 17'h0_0001;

  always_comb
  begin
    r_next = r_reg;
    r_next.done = 1'b0;
    r_next.cnt = cnt_inc;
    case (r_reg.st)
      owvc_pkg::OWVC_H_IDLE:
      begin
        r_next.oe = 1'b1;
        r_next.lvl = idle_high_i;
        if (send_i)
        begin
          r_next.sh = data_i;
          r_next.idx = 3'h0;
          r_next.lvl = 1'b1;
          r_next.cnt = 17'h0_0000;
          r_next.busy = 1'b1;
          r_next.ack = 1'b0;
          r_next.st = owvc_pkg::OWVC_H_START;
        end
      end
      owvc_pkg::OWVC_H_START:
      begin
        if (r_reg.cnt == (owvc_pkg::H_START_CYC - 17'h0_0001))
        begin
          r_next.lvl = 1'b0;
          r_next.cnt = 17'h0_0000;
          r_next.st = owvc_pkg::OWVC_H_LOW;
        end
      end
      owvc_pkg::OWVC_H_LOW:
      begin
        if (r_reg.cnt == (low_len - 17'h0_0001))
        begin
          r_next.lvl = 1'b1;
          r_next.cnt = 17'h0_0000;
          r_next.st = owvc_pkg::OWVC_H_HIGH;
        end
      end
      owvc_pkg::OWVC_H_HIGH:
      begin
        if (r_reg.cnt == (high_len - 17'h0_0001))
        begin
          r_next.lvl = 1'b0;
          r_next.cnt = 17'h0_0000;
          r_next.sh = {r_reg.sh[6:0], 1'b0};
          r_next.idx = r_reg.idx + 3'h1;
          r_next.st = (r_reg.idx == owvc_pkg::LAST_BIT) ? owvc_pkg::OWVC_H_EOS
                                                         : owvc_pkg::OWVC_H_LOW;
        end
      end
      owvc_pkg::OWVC_H_EOS:
      begin
        if (r_reg.cnt == (owvc_pkg::H_EOS_CYC - 17'h0_0001))
        begin
          r_next.oe = 1'b0;
          r_next.cnt = 17'h0_0000;
          r_next.st = owvc_pkg::OWVC_H_WAIT;
        end
      end
      owvc_pkg::OWVC_H_WAIT:
      begin
        if (!link.line)
        begin
          r_next.cnt = 17'h0_0001;
          r_next.st = owvc_pkg::OWVC_H_ACK;
        end
        else if (r_reg.cnt == (owvc_pkg::H_ACK_WAIT_CYC - 17'h0_0001))
        begin
          r_next.st = owvc_pkg::OWVC_H_IDLE;
          r_next.busy = 1'b0;
          r_next.done = 1'b1;
        end
      end
      owvc_pkg::OWVC_H_ACK:
      begin
        // A pulse that never ends is reported as no acknowledge
        if (link.line || (r_reg.cnt > ACK_MAX_CYC))
        begin
          r_next.ack = link.line && (r_reg.cnt >= ACK_MIN_CYC);
          r_next.st = owvc_pkg::OWVC_H_IDLE;
          r_next.busy = 1'b0;
          r_next.done = 1'b1;
        end
      end
      default:
      begin
        r_next.st = owvc_pkg::OWVC_H_IDLE;
        r_next.busy = 1'b0;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      r_reg.st <= owvc_pkg::OWVC_H_IDLE;
      r_reg.cnt <= 17'h0_0000;
      r_reg.idx <= 3'h0;
      r_reg.sh <= 8'h00;
      r_reg.lvl <= 1'b1;
      r_reg.oe <= 1'b0;
      r_reg.busy <= 1'b0;
      r_reg.done <= 1'b0;
      r_reg.ack <= 1'b0;
    end
    else
    begin
      r_reg <= r_next;
    end
  end

  assign link.host_o = r_reg.lvl;
  assign link.host_oe = r_reg.oe;
  assign busy_o = r_reg.busy;
  assign done_o = r_reg.done;
  assign ack_o = r_reg.ack;

endmodule

// [design/owvc_if.sv]
// Shared mode/data wire between host and regulator command receiver.
// Assumes a pull-up: the wire is high unless a driver with enable pulls it low.
`timescale 1ns/1ps
interface owvc_if;
  logic host_o;
  logic host_oe;
  logic dev_o;
  logic dev_oe;
  logic line;

  assign line = (host_oe ? host_o : 1'b1) & (dev_oe ? dev_o : 1'b1);

  modport host (output host_o, output host_oe, input line);
  modport dev (output dev_o, output dev_oe, input line);
endinterface

// [design/owvc_pkg.sv]
// Shared constants and state types of the single-wire voltage command link.
// Assumes one 200 MHz reference clock on both ends of the link.
package owvc_pkg;
  localparam int CLK_MHZ = 200;
  localparam int CNT_W = 17;
  localparam int BITS_PER_FRAME = 8;
  localparam logic [2:0] LAST_BIT = 3'h7;

  // Times in microseconds
  localparam int PHASE_MIN_US = 2;
  localparam int FIRST_MAX_US = 200;
  localparam int SECOND_MAX_US = 400;
  localparam int START_MIN_US = 2;
  localparam int EOS_MIN_US = 2;
  localparam int ACK_MIN_US = 400;
  localparam int ACK_MAX_US = 520;
  localparam int TIMEOUT_MAX_US = 520;
  localparam int H_SHORT_US = 10;
  localparam int H_LONG_US = 30;
  localparam int H_START_US = 4;
  localparam int H_EOS_US = 4;
  localparam int H_ACK_WAIT_US = 4;

  // Cycle counts; all figures are whole cycles at 200 MHz
  localparam logic [CNT_W-1:0] PHASE_MIN_CYC = CNT_W'(PHASE_MIN_US * CLK_MHZ);
  localparam logic [CNT_W-1:0] FIRST_MAX_CYC = CNT_W'(FIRST_MAX_US * CLK_MHZ);
  localparam logic [CNT_W-1:0] SECOND_MAX_CYC = CNT_W'(SECOND_MAX_US * CLK_MHZ);
  localparam logic [CNT_W-1:0] START_MIN_CYC = CNT_W'(START_MIN_US * CLK_MHZ);
  localparam logic [CNT_W-1:0] EOS_MIN_CYC = CNT_W'(EOS_MIN_US * CLK_MHZ);
  localparam logic [CNT_W-1:0] ACK_MIN_CYC = CNT_W'(ACK_MIN_US * CLK_MHZ);
  localparam logic [CNT_W-1:0] ACK_MAX_CYC = CNT_W'(ACK_MAX_US * CLK_MHZ);
  // Just past the longest legal low phase, well inside the timeout limit
  localparam logic [CNT_W-1:0] TIMEOUT_CYC = CNT_W'(SECOND_MAX_US * CLK_MHZ + 1);
  localparam logic [CNT_W-1:0] H_SHORT_CYC = CNT_W'(H_SHORT_US * CLK_MHZ);
  localparam logic [CNT_W-1:0] H_LONG_CYC = CNT_W'(H_LONG_US * CLK_MHZ);
  localparam logic [CNT_W-1:0] H_START_CYC = CNT_W'(H_START_US * CLK_MHZ);
  localparam logic [CNT_W-1:0] H_EOS_CYC = CNT_W'(H_EOS_US * CLK_MHZ);
  localparam logic [CNT_W-1:0] H_ACK_WAIT_CYC = CNT_W'(H_ACK_WAIT_US * CLK_MHZ);

  // Values after reset
  localparam logic SAVE_MODE_RST = 1'b1;
  localparam logic PWM_FORCE_RST = 1'b0;

  typedef enum logic [5:0] {
    OWVC_D_IDLE = 6'h01,
    OWVC_D_LOW = 6'h02,
    OWVC_D_HIGH = 6'h04,
    OWVC_D_EOS = 6'h08,
    OWVC_D_ACK = 6'h10,
    OWVC_D_REL = 6'h20
  } owvc_dstate_t;

  typedef enum logic [6:0] {
    OWVC_H_IDLE = 7'h01,
    OWVC_H_START = 7'h02,
    OWVC_H_LOW = 7'h04,
    OWVC_H_HIGH = 7'h08,
    OWVC_H_EOS = 7'h10,
    OWVC_H_WAIT = 7'h20,
    OWVC_H_ACK = 7'h40
  } owvc_hstate_t;
endpackage

// [verif/owvc_chk.sv]
// Wire checker for the single-wire command link.
// Assumes it sits beside the interface, acknowledge always enabled.
`timescale 1ns/1ps
module owvc_chk #(
  parameter int ACK_CYC = 80
) (
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  input wire logic host_o,
  input wire logic host_oe,
  input wire logic dev_o,
  input wire logic dev_oe,
  input wire logic line
);
  int low_run;
  int high_run;
  int ack_run;
  int last_low;

  // Run lengths in cycles as the device samples them
  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      low_run <= 0;
      high_run <= 0;
      ack_run <= 0;
      last_low <= 0;
    end
    else
    begin
      low_run <= line ? 0 : low_run + 1;
      high_run <= line ? high_run + 1 : 0;
      ack_run <= dev_oe ? ack_run + 1 : 0;
      last_low <= (line && low_run != 0) ? low_run : last_low;
    end
  end

  default clocking @(posedge ref_clk_i);
  endclocking
  default disable iff (!arst_n_i);

  sequence s_eos_release;
    $fell(host_oe) ##0 line;
  endsequence
  sequence s_ack_begin;
    $rose(dev_oe);
  endsequence

  a_pull_only_low: assert property (dev_oe |-> !dev_o)
    else $error("device drove the wire high");
  a_host_stays_off: assert property (dev_oe |-> !host_oe)
    else $error("host drove during acknowledge");
  a_ack_after_rise: assert property (s_ack_begin |-> $past(line) && !$past(line, 2))
    else $error("acknowledge without end of stream");
  a_ack_prompt: assert property (s_eos_release |-> ##[1:2] dev_oe)
    else $error("acknowledge missing after release");
  a_ack_exact_len: assert property ($fell(dev_oe) |-> ack_run == ACK_CYC)
    else $error("acknowledge length wrong");
  a_ack_bounded: assert property (dev_oe |-> ack_run < ACK_CYC)
    else $error("acknowledge too long");
  a_eos_length: assert property ($fell(host_oe) |-> low_run >= owvc_pkg::EOS_MIN_CYC)
    else $error("end of stream too short");
  a_low_phase_ok: assert property ($rose(line) && host_oe |->
    low_run >= owvc_pkg::PHASE_MIN_CYC && low_run <= owvc_pkg::SECOND_MAX_CYC)
    else $error("low phase out of range");
  // Own acknowledge fall follows a one-cycle high, so only host-driven falls count
  a_high_phase_ok: assert property ($fell(line) && host_oe |->
    high_run >= owvc_pkg::PHASE_MIN_CYC)
    else $error("high phase too short");
  a_bit_ratio: assert property ($fell(line) && host_oe |->
    high_run >= 2 * last_low || last_low >= 2 * high_run)
    else $error("bit phase ratio below two");
endmodule

// [verif/testbench.sv]
// Self-checking bench: host and device ends joined by the link interface.
// Assumes shortened device limits so a frame fits a short run.
`timescale 1ns/1ps
module testbench;
  logic ref_clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic send_i = 1'b0;
  logic [7:0] data_i = 8'h00;
  logic idle_high_i = 1'b1;
  logic ack_en_i = 1'b1;
  logic [7:0] data_o;
  logic data_valid_o, frame_err_o, save_mode_o, pwm_force_o, busy_o, done_o, ack_o;
  int failures = 0;
  int checks_done = 0;
  int n_valid = 0;
  int n_err = 0;
  int cyc;

  owvc_if bus();
  // Limits cut so mode timeouts fit the run; host phases still legal
  owvc_dev #(.SECOND_MAX_CYC(17'h0_2ee0), .TIMEOUT_CYC(17'h0_2ee1),
    .ACK_CYC(17'h0_0050)) owvc_dev_inst (
    .ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .link(bus.dev), .ack_en_i(ack_en_i),
    .data_o(data_o), .data_valid_o(data_valid_o), .frame_err_o(frame_err_o),
    .save_mode_o(save_mode_o), .pwm_force_o(pwm_force_o));
  owvc_host #(.ACK_MIN_CYC(17'h0_0050)) owvc_host_inst (
    .ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .link(bus.host), .send_i(send_i),
    .data_i(data_i), .idle_high_i(idle_high_i), .busy_o(busy_o), .done_o(done_o),
    .ack_o(ack_o));
  owvc_chk #(.ACK_CYC(80)) owvc_chk_inst (
    .ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .host_o(bus.host_o), .host_oe(bus.host_oe),
    .dev_o(bus.dev_o), .dev_oe(bus.dev_oe), .line(bus.line));

  always #2.5 ref_clk_i = ~ref_clk_i;

  // Pulses are one cycle wide, so count them on every rising edge
  always @(posedge ref_clk_i)
  begin
    if (data_valid_o === 1'b1)
      n_valid++;
    if (frame_err_o === 1'b1)
      n_err++;
  end

  task check(input logic [16:0] seen, input logic [16:0] exp, input string what);
    checks_done++;
    if (seen !== exp)
    begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task give_verdict;
    $display("failures %0d checks %0d", failures, checks_done);
    if (failures == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Bounded wait; a miss ends the run
  task automatic wait_high(ref logic s, input int lim, input string what);
    cyc = 0;
    while (s !== 1'b1 && cyc < lim)
    begin
      @(negedge ref_clk_i);
      cyc++;
    end
    if (s !== 1'b1)
    begin
      failures++;
      $display("wrong value %s expected 1 seen timeout", what);
      give_verdict();
    end
  endtask

  task t_reset;
    check(save_mode_o, 1'b1, "save_mode_o");
    check(pwm_force_o, 1'b0, "pwm_force_o");
    check(busy_o, 1'b0, "busy_o");
  endtask

  task t_static_high;
    wait_high(pwm_force_o, 12100, "pwm_force_o");
    check(cyc >= 12000, 1'b1, "pwm delay");
    check(save_mode_o, 1'b0, "save_mode_o");
  endtask

  task t_frame;
    data_i = 8'ha5;
    send_i = 1'b1;
    @(negedge ref_clk_i);
    send_i = 1'b0;
    check(busy_o, 1'b1, "busy_o");
    // Start, 8 bits, end of stream and acknowledge at the least
    wait_high(done_o, 70000, "done_o");
    check(cyc >= 65680, 1'b1, "frame length");
    check(ack_o, 1'b1, "ack_o");
    check(data_o, 8'ha5, "data_o");
    check(17'(n_valid), 17'h0_0001, "valid pulses");
    check(17'(n_err), 17'h0_0000, "error pulses");
  endtask

  task t_timeout;
    repeat (1000) @(negedge ref_clk_i);
    idle_high_i = 1'b0;
    wait_high(save_mode_o, 12100, "save_mode_o");
    check(cyc >= 12000 && cyc <= 12004, 1'b1, "save delay");
    // A long low after a long high opens a frame, so the timeout aborts it
    check(frame_err_o, 1'b1, "frame_err_o");
    @(negedge ref_clk_i);
    check(pwm_force_o, 1'b0, "pwm_force_o");
    check(17'(n_err), 17'h0_0001, "error pulses");
  endtask

  initial
  begin
    repeat (3) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    arst_n_i = 1'b1;
    t_reset();
    t_static_high();
    t_frame();
    t_timeout();
    give_verdict();
  end
endmodule
